// ---- cdc_defs.vh ----
/*
 Constants for the capacitive channel offset and calibration block:
 register pointers, reset values, field positions and converter sizes.
 Assumes it is included by bare name from every design file that needs it.
*/
`ifndef CDC_DEFS_VH
`define CDC_DEFS_VH

// Register pointers
`define CDC_A_RES_H 8'h01
`define CDC_A_RES_M 8'h02
`define CDC_A_RES_L 8'h03
`define CDC_A_DAC_POS 8'h0b
`define CDC_A_DAC_NEG 8'h0c
`define CDC_A_OFF_H 8'h0d
`define CDC_A_OFF_L 8'h0e
`define CDC_A_CGAIN_H 8'h0f
`define CDC_A_CGAIN_L 8'h10
`define CDC_A_VGAIN_H 8'h11
`define CDC_A_VGAIN_L 8'h12

// Reset values and the mid-scale code
`define CDC_DAC_RST 8'h00
`define CDC_OFF_RST 16'h8000
`define CDC_GAIN_RST 16'h0000
`define CDC_MID_CODE 24'h800000
`define CDC_RES_RST 24'h800000

// Offset DAC register fields
`define CDC_DAC_EN_BIT 7
`define CDC_DAC_CODE_HI 5

// Converter sizes and rates, device address
`define CDC_DEC_LOG 7
`define CDC_MOD_DIV 16
`define CDC_SETTLE 2'h3
`define CDC_DEV_ADDR 7'h48

`endif

// ---- cdc_sinc3.v ----
/*
 Third-order sinc decimator for the modulator one-bit stream.
 Assumes sample_en is a one-cycle pulse at the modulator rate and that
 mod_bit is valid in that cycle.
*/
`timescale 1ns/1ps
`include "cdc_defs.vh"

module cdc_sinc3 #(
    parameter DEC_LOG = `CDC_DEC_LOG
) (
    // Clock and reset
    input wire sys_clk,
    input wire resetn,
    // Bit stream
    input wire sample_en,
    input wire mod_bit,
    // Decimated result, signed, full scale is plus or minus 2^23
    output reg out_valid,
    output reg [24:0] out_code
);
    localparam W = 3 * DEC_LOG + 1;
    localparam SH = 24 - 3 * DEC_LOG;
    localparam [W:0] HALF = {{(W - 3 * DEC_LOG + 1){1'b0}}, 1'b1, {(3 * DEC_LOG - 1){1'b0}}};

    reg [W-1:0] int1_q, int2_q, int3_q;
    reg [W-1:0] dly1_q, dly2_q, dly3_q;
    reg [DEC_LOG-1:0] cnt_q;
    reg [1:0] settle_q;
    reg [W-1:0] comb1, comb2, comb3;
    wire signed [W:0] centred;
    wire [24:0] ext;

    // Comb section at the decimated rate, wrap-around arithmetic is intended
    always @* begin
        comb1 = int3_q - dly1_q;
        comb2 = comb1 - dly2_q;
        comb3 = comb2 - dly3_q;
    end

    // Centre the unsigned count so zero differential input reads zero
    assign centred = $signed({1'b0, comb3}) - $signed(HALF);
    assign ext = {{(24 - W){centred[W]}}, centred};

    // Integrators, decimation counter and output register
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            int1_q <= {W{1'b0}};
            int2_q <= {W{1'b0}};
            int3_q <= {W{1'b0}};
            dly1_q <= {W{1'b0}};
            dly2_q <= {W{1'b0}};
            dly3_q <= {W{1'b0}};
            cnt_q <= {DEC_LOG{1'b0}};
            settle_q <= 2'h0;
            out_valid <= 1'b0;
            out_code <= 25'h0000000;
        end else begin
            out_valid <= 1'b0;
            if (sample_en) begin
                int1_q <= int1_q + {{(W - 1){1'b0}}, mod_bit};
                int2_q <= int2_q + int1_q;
                int3_q <= int3_q + int2_q;
                cnt_q <= cnt_q + 1'b1;
                if (&cnt_q) begin
                    dly1_q <= int3_q;
                    dly2_q <= comb1;
                    dly3_q <= comb2;
                    // The first outputs carry start-up garbage of the pipeline
                    if (settle_q == `CDC_SETTLE) begin
                        out_valid <= 1'b1;
                        out_code <= ext << SH;
                    end else begin
                        settle_q <= settle_q + 1'b1;
                    end
                end
            end
        end
    end
endmodule

// ---- cdc_cap_channel.v ----
/*
 Digital side of the capacitive channel: serial register port, offset DAC
 settings, calibration coefficients, result scaling and offset calibration.
 Assumes scl and sda are already synchronous to sys_clk and that an
 open-drain pad combines sda_out and sda_oe.
*/
`timescale 1ns/1ps
`include "cdc_defs.vh"

module cdc_cap_channel #(
    parameter MOD_DIV = `CDC_MOD_DIV,
    parameter [6:0] DEV_ADDR = `CDC_DEV_ADDR
) (
    // Clock and reset
    input wire sys_clk,
    input wire resetn,
    // Serial register port
    input wire scl,
    input wire sda_in,
    output reg sda_out,
    output reg sda_oe,
    // Modulator and factory storage
    input wire mod_bit,
    input wire [15:0] otp_cap_gain,
    input wire [15:0] otp_volt_gain,
    input wire cal_offset_start,
    // Analog controls and results
    output reg pos_offset_dac_connect,
    output reg [5:0] pos_offset_dac_code,
    output reg neg_offset_dac_connect,
    output reg [5:0] neg_offset_dac_code,
    output reg [23:0] result_code,
    output reg result_strobe,
    output reg cal_busy
);
    localparam [4:0] ST_IDLE = 5'h01;
    localparam [4:0] ST_RX = 5'h02;
    localparam [4:0] ST_ACKO = 5'h04;
    localparam [4:0] ST_TX = 5'h08;
    localparam [4:0] ST_ACKI = 5'h10;
    localparam [2:0] K_ADDR = 3'h1;
    localparam [2:0] K_PTR = 3'h2;
    localparam [2:0] K_DATA = 3'h4;

    reg [4:0] st_q;
    reg [2:0] kind_q;
    reg [3:0] bit_q;
    reg [7:0] sh_q, ptr_q, tx_q;
    reg rw_q, nack_q, scl_q, sda_q, load_q;
    reg [7:0] dac_pos_q, dac_neg_q;
    reg [15:0] cap_off_q, cap_gain_q, volt_gain_q;
    reg [7:0] div_q;
    reg mod_en_q, mod_bit_q;
    reg [7:0] rd_byte;
    reg [23:0] scaled_code;
    reg [15:0] cal_coef;
    wire filt_valid;
    wire [24:0] filt_code;
    wire start_ev, stop_ev, scl_rise, scl_fall, wr_ev;
    wire signed [24:0] raw_s;
    wire signed [16:0] coef_c;
    wire signed [25:0] off_term, diff;
    wire signed [42:0] prod;
    wire signed [27:0] scaled;

    // Bus conditions seen on the sampled pins
    assign start_ev = scl && scl_q && sda_q && !sda_in;
    assign stop_ev = scl && scl_q && !sda_q && sda_in;
    assign scl_rise = scl && !scl_q;
    assign scl_fall = !scl && scl_q;
    assign wr_ev = (st_q == ST_RX) && scl_fall && (bit_q == 4'h8) && (kind_q == K_DATA);

    // Modulator rate enable from the system clock
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            div_q <= 8'h00;
            mod_en_q <= 1'b0;
            mod_bit_q <= 1'b0;
        end else begin
            mod_en_q <= (div_q == MOD_DIV - 1);
            div_q <= (div_q == MOD_DIV - 1) ? 8'h00 : div_q + 8'h01;
            mod_bit_q <= mod_bit;
        end
    end

    cdc_sinc3 #(
        .DEC_LOG(`CDC_DEC_LOG)
    ) u_filter (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .sample_en(mod_en_q),
        .mod_bit(mod_bit_q),
        .out_valid(filt_valid),
        .out_code(filt_code)
    );

    // Offset in 31.25 aF steps is 64 result codes per step
    assign raw_s = filt_code;
    assign coef_c = $signed({1'b0, cap_off_q}) - $signed({1'b0, `CDC_OFF_RST});
    assign off_term = {{3{coef_c[16]}}, coef_c, 6'h00};
    assign diff = {raw_s[24], raw_s} - off_term;
    assign prod = diff * $signed({1'b0, cap_gain_q});
    assign scaled = prod[42:15];

    // Clamp to the 24-bit offset-binary range, mid-scale is zero charge
    always @* begin
        if (scaled[27:23] != {5{scaled[27]}}) begin
            scaled_code = scaled[27] ? 24'h000000 : 24'hffffff;
        end else begin
            scaled_code = scaled[23:0] ^ `CDC_MID_CODE;
        end
        // Coefficient that puts the present input at mid-scale
        if (raw_s[24:21] != {4{raw_s[24]}}) begin
            cal_coef = raw_s[24] ? 16'h0000 : 16'hffff;
        end else begin
            cal_coef = {~raw_s[21], raw_s[20:6]};
        end
    end

    // Read data for the byte at the pointer
    always @* begin
        case (ptr_q)
            `CDC_A_RES_H: rd_byte = result_code[23:16];
            `CDC_A_RES_M: rd_byte = result_code[15:8];
            `CDC_A_RES_L: rd_byte = result_code[7:0];
            `CDC_A_DAC_POS: rd_byte = dac_pos_q;
            `CDC_A_DAC_NEG: rd_byte = dac_neg_q;
            `CDC_A_OFF_H: rd_byte = cap_off_q[15:8];
            `CDC_A_OFF_L: rd_byte = cap_off_q[7:0];
            `CDC_A_CGAIN_H: rd_byte = cap_gain_q[15:8];
            `CDC_A_CGAIN_L: rd_byte = cap_gain_q[7:0];
            `CDC_A_VGAIN_H: rd_byte = volt_gain_q[15:8];
            `CDC_A_VGAIN_L: rd_byte = volt_gain_q[7:0];
            default: rd_byte = 8'h00;
        endcase
    end

    // Register file; calibration write-back wins over a host write
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            dac_pos_q <= `CDC_DAC_RST;
            dac_neg_q <= `CDC_DAC_RST;
            cap_off_q <= `CDC_OFF_RST;
            cap_gain_q <= `CDC_GAIN_RST;
            volt_gain_q <= `CDC_GAIN_RST;
            load_q <= 1'b1;
            cal_busy <= 1'b0;
            result_code <= `CDC_RES_RST;
            result_strobe <= 1'b0;
        end else begin
            result_strobe <= 1'b0;
            if (wr_ev) begin
                case (ptr_q)
                    `CDC_A_DAC_POS: dac_pos_q <= sh_q;
                    `CDC_A_DAC_NEG: dac_neg_q <= sh_q;
                    `CDC_A_OFF_H: cap_off_q[15:8] <= sh_q;
                    `CDC_A_OFF_L: cap_off_q[7:0] <= sh_q;
                    `CDC_A_CGAIN_H: cap_gain_q[15:8] <= sh_q;
                    `CDC_A_CGAIN_L: cap_gain_q[7:0] <= sh_q;
                    `CDC_A_VGAIN_H: volt_gain_q[15:8] <= sh_q;
                    `CDC_A_VGAIN_L: volt_gain_q[7:0] <= sh_q;
                    default: ;
                endcase
            end
            // Factory gains override anything written before the load
            if (load_q) begin
                load_q <= 1'b0;
                cap_gain_q <= otp_cap_gain;
                volt_gain_q <= otp_volt_gain;
            end
            if (filt_valid) begin
                if (cal_busy) begin
                    cap_off_q <= cal_coef;
                    cal_busy <= 1'b0;
                end else begin
                    result_code <= scaled_code;
                    result_strobe <= 1'b1;
                end
            end
            // A new arm in the write-back cycle wins over the clear
            if (cal_offset_start) begin
                cal_busy <= 1'b1;
            end
        end
    end

    // Offset DAC controls follow the register bits
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pos_offset_dac_connect <= 1'b0;
            pos_offset_dac_code <= 6'h00;
            neg_offset_dac_connect <= 1'b0;
            neg_offset_dac_code <= 6'h00;
        end else begin
            pos_offset_dac_connect <= dac_pos_q[`CDC_DAC_EN_BIT];
            pos_offset_dac_code <= dac_pos_q[`CDC_DAC_CODE_HI:0];
            neg_offset_dac_connect <= dac_neg_q[`CDC_DAC_EN_BIT];
            neg_offset_dac_code <= dac_neg_q[`CDC_DAC_CODE_HI:0];
        end
    end

    // Serial slave: address, pointer, then data with pointer increment
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            st_q <= ST_IDLE;
            kind_q <= K_ADDR;
            bit_q <= 4'h0;
            sh_q <= 8'h00;
            ptr_q <= 8'h00;
            tx_q <= 8'h00;
            rw_q <= 1'b0;
            nack_q <= 1'b0;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            sda_out <= 1'b0;
            sda_oe <= 1'b0;
        end else begin
            scl_q <= scl;
            sda_q <= sda_in;
            if (start_ev) begin
                st_q <= ST_RX;
                kind_q <= K_ADDR;
                bit_q <= 4'h0;
                sda_oe <= 1'b0;
            end else if (stop_ev) begin
                st_q <= ST_IDLE;
                sda_oe <= 1'b0;
            end else begin
                case (st_q)
                    ST_IDLE: ;
                    ST_RX: begin
                        if (scl_rise && bit_q != 4'h8) begin
                            sh_q <= {sh_q[6:0], sda_in};
                            bit_q <= bit_q + 4'h1;
                        end else if (scl_fall && bit_q == 4'h8) begin
                            bit_q <= 4'h0;
                            if (kind_q == K_ADDR && sh_q[7:1] != DEV_ADDR) begin
                                st_q <= ST_IDLE;
                            end else begin
                                st_q <= ST_ACKO;
                                sda_oe <= 1'b1;
                                if (kind_q == K_ADDR) begin
                                    rw_q <= sh_q[0];
                                end else if (kind_q == K_PTR) begin
                                    ptr_q <= sh_q;
                                end else begin
                                    ptr_q <= ptr_q + 8'h01;
                                end
                            end
                        end
                    end
                    ST_ACKO: begin
                        if (scl_fall) begin
                            if (rw_q) begin
                                st_q <= ST_TX;
                                tx_q <= rd_byte;
                                sda_oe <= !rd_byte[7];
                                ptr_q <= ptr_q + 8'h01;
                                bit_q <= 4'h1;
                            end else begin
                                st_q <= ST_RX;
                                sda_oe <= 1'b0;
                                kind_q <= (kind_q == K_ADDR) ? K_PTR : K_DATA;
                            end
                        end
                    end
                    ST_TX: begin
                        if (scl_fall) begin
                            if (bit_q == 4'h8) begin
                                st_q <= ST_ACKI;
                                sda_oe <= 1'b0;
                            end else begin
                                tx_q <= {tx_q[6:0], 1'b0};
                                sda_oe <= !tx_q[6];
                                bit_q <= bit_q + 4'h1;
                            end
                        end
                    end
                    ST_ACKI: begin
                        if (scl_rise) begin
                            nack_q <= sda_in;
                        end else if (scl_fall) begin
                            if (nack_q) begin
                                st_q <= ST_IDLE;
                            end else begin
                                st_q <= ST_TX;
                                tx_q <= rd_byte;
                                sda_oe <= !rd_byte[7];
                                ptr_q <= ptr_q + 8'h01;
                                bit_q <= 4'h1;
                            end
                        end
                    end
                    default: st_q <= ST_IDLE;
                endcase
            end
        end
    end
endmodule

// ---- cdc_cap_channel_chk.sv ----
/*
 Checker for cdc_cap_channel: DAC outputs, result timing and calibration.
 Assumes one clock domain with an asynchronous active-low reset.
*/
`timescale 1ns/1ps
module cdc_chk #(
    parameter MOD_DIV = 16
) (
    // Clock and reset
    input wire sys_clk,
    input wire resetn,
    // Serial port
    input wire scl,
    input wire sda_in,
    input wire sda_out,
    input wire sda_oe,
    // Modulator and factory storage
    input wire mod_bit,
    input wire [15:0] otp_cap_gain,
    input wire [15:0] otp_volt_gain,
    input wire cal_offset_start,
    // Analog controls and results
    input wire pos_offset_dac_connect,
    input wire [5:0] pos_offset_dac_code,
    input wire neg_offset_dac_connect,
    input wire [5:0] neg_offset_dac_code,
    input wire [23:0] result_code,
    input wire result_strobe,
    input wire cal_busy
);
    reg [15:0] cal_cnt_q;
    wire [15:0] cal_cnt_d = cal_busy ? cal_cnt_q + 16'h0001 : 16'h0000;

    // Length of the running calibration, so its wait can be bounded
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cal_cnt_q <= 16'h0000;
        end else begin
            cal_cnt_q <= cal_cnt_d;
        end
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    // Results come at least nine cycles apart, never in neighbouring cycles
    sequence s_no_strobe;
        !result_strobe [*8];
    endsequence
    sequence s_cal_quiet;
        !result_strobe ##1 !result_strobe;
    endsequence

    AST_RST_DAC: assert property ($rose(resetn) |-> {pos_offset_dac_connect, neg_offset_dac_connect} == 2'h0)
        else $error("offset DAC connect not cleared by reset");
    AST_DAC_POS_AFTER_FALL: assert property ($changed({pos_offset_dac_connect, pos_offset_dac_code}) |-> !scl)
        else $error("positive DAC setting moved while scl high");
    AST_DAC_NEG_AFTER_FALL: assert property ($changed({neg_offset_dac_connect, neg_offset_dac_code}) |-> !scl)
        else $error("negative DAC setting moved while scl high");
    AST_STROBE_PULSE: assert property (result_strobe |=> s_no_strobe)
        else $error("result strobe longer than one cycle");
    AST_RESULT_HOLD: assert property (!result_strobe |-> $stable(result_code))
        else $error("result changed without strobe");
    AST_CAL_SILENT: assert property ($fell(cal_busy) |-> s_cal_quiet)
        else $error("calibration output produced a result strobe");
    AST_CAL_BOUND: assert property (cal_cnt_q <= 3 * 128 * MOD_DIV)
        else $error("calibration did not finish in time");
    AST_RST_RESULT: assert property ($rose(resetn) |-> result_code == 24'h800000 && !cal_busy)
        else $error("result not mid-scale after reset");
endmodule

bind cdc_cap_channel cdc_chk #(.MOD_DIV(MOD_DIV)) u_chk (.sys_clk, .resetn, .scl, .sda_in, .sda_out, .sda_oe,
    .mod_bit, .otp_cap_gain, .otp_volt_gain, .cal_offset_start, .pos_offset_dac_connect, .pos_offset_dac_code,
    .neg_offset_dac_connect, .neg_offset_dac_code, .result_code, .result_strobe, .cal_busy);

// ---- cdc_host_model.sv ----
/*
 Behavioural host controller on the two-wire register port.
 Assumes the testbench resolves the open-drain line with a pull-up.
*/
`timescale 1ns/1ps
module cdc_host_model #(
    parameter [6:0] DEV_ADDR = 7'h48
) (
    // Clock
    input wire sys_clk,
    // Two-wire lines
    input wire sda_line,
    output reg scl,
    output reg sda_low
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    task tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    // One bit; sending 1 releases the line so the device may answer
    task bit_io(input logic b, output logic r);
        sda_low <= !b;
        tick(2);
        scl <= 1'b1;
        tick(2);
        @(negedge sys_clk);
        r = sda_line;
        tick(2);
        scl <= 1'b0;
        tick(2);
    endtask

    task byte_io(input logic [7:0] d, input logic exp_a, output logic [7:0] r, inout logic ok);
        logic a;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
        bit_io(1'b1, a);
        ok = ok & (a === exp_a);
    endtask

    // Start, or repeated start when scl is low
    task start_cond;
        sda_low <= 1'b0;
        tick(2);
        scl <= 1'b1;
        tick(4);
        sda_low <= 1'b1;
        tick(4);
        scl <= 1'b0;
        tick(2);
    endtask

    task stop_cond;
        sda_low <= 1'b1;
        tick(2);
        scl <= 1'b1;
        tick(4);
        sda_low <= 1'b0;
        tick(4);
    endtask

    // Bit 6 of a single-byte offset DAC write is masked, so every such DAC write here clears it
    // Write n bytes (1 or 2, high byte first) from pointer p
    task write_reg(input logic [7:0] p, input logic [15:0] d, input int n, output logic ok);
        logic [7:0] r;
        ok = 1'b1;
        start_cond;
        byte_io({DEV_ADDR, 1'b0}, 1'b0, r, ok);
        byte_io(p, 1'b0, r, ok);
        if (n == 2) byte_io(d[15:8], 1'b0, r, ok);
        byte_io((p == 8'h0b || p == 8'h0c) ? d[7:0] & 8'hbf : d[7:0], 1'b0, r, ok);
        stop_cond;
    endtask

    // Single-byte read, ended by a not-acknowledge
    task read_reg(input logic [7:0] p, output logic [7:0] d, output logic ok);
        ok = 1'b1;
        start_cond;
        byte_io({DEV_ADDR, 1'b0}, 1'b0, d, ok);
        byte_io(p, 1'b0, d, ok);
        start_cond;
        byte_io({DEV_ADDR, 1'b1}, 1'b0, d, ok);
        byte_io(8'hff, 1'b1, d, ok);
        stop_cond;
    endtask
endmodule

// ---- cdc_cap_channel_test.sv ----
/*
 Testbench for cdc_cap_channel: registers, DAC outputs, scaling, calibration.
 Assumes cdc_host_model as serial host and the bound checker.
*/
`timescale 1ns/1ps
`include "cdc_defs.vh"
module cdc_cap_channel_test;
    // Short modulator period: one result every 256 cycles
    localparam int MD = 2;
    // Nine ones in sixteen bits is one eighth of positive full scale
    localparam logic [23:0] RAW = 24'h100000;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic mod_bit = 1'b0;
    logic cal_offset_start = 1'b0;
    logic [4:0] mod_cnt_q = 5'h00;
    logic [15:0] otp_cap_gain = 16'h8000;
    logic [15:0] otp_volt_gain = 16'h1234;
    logic [7:0] ptrs [8] = '{8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h10, 8'h11, 8'h12};
    logic [7:0] rstv [8] = '{8'h00, 8'h00, 8'h80, 8'h00, 8'h80, 8'h00, 8'h12, 8'h34};
    logic [7:0] dv [3] = '{8'ha5, 8'h3f, 8'h80};
    wire scl, sda_low, sda_out, sda_oe, sda_in;
    wire pos_offset_dac_connect, neg_offset_dac_connect, result_strobe, cal_busy;
    wire [5:0] pos_offset_dac_code, neg_offset_dac_code;
    wire [23:0] result_code;
    int err_count = 0;
    int checks = 0;
    logic [7:0] rd;
    logic ok;

    // Pulled-up line, low when either party drives it
    assign sda_in = !(sda_low || (sda_oe && !sda_out));
    always #5 sys_clk = ~sys_clk;

    // Density pattern advances one slot per modulator sample
    always @(posedge sys_clk) begin
        mod_cnt_q <= mod_cnt_q + 5'h01;
        mod_bit <= (mod_cnt_q[4:1] < 4'h9);
    end

    cdc_host_model host (.sys_clk(sys_clk), .sda_line(sda_in), .scl(scl), .sda_low(sda_low));
    cdc_cap_channel #(.MOD_DIV(MD)) dut (.sys_clk, .resetn, .scl, .sda_in, .sda_out, .sda_oe, .mod_bit,
        .otp_cap_gain, .otp_volt_gain, .cal_offset_start, .pos_offset_dac_connect, .pos_offset_dac_code,
        .neg_offset_dac_connect, .neg_offset_dac_code, .result_code, .result_strobe, .cal_busy);

    task check(input string what, input logic [23:0] seen, input logic [23:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task final_report;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task do_reset(input int n);
        resetn <= 1'b0;
        repeat (n) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (2) @(posedge sys_clk);
    endtask

    task rd_chk(input logic [7:0] p, input logic [7:0] exp);
        host.read_reg(p, rd, ok);
        check($sformatf("ack %h", p), ok, 1);
        check($sformatf("reg %h", p), rd, exp);
    endtask

    task wr_chk(input logic [7:0] p, input logic [15:0] d, input int n);
        host.write_reg(p, d, n, ok);
        check($sformatf("wr ack %h", p), ok, 1);
    endtask

    // Each wait is bounded well beyond four conversion periods
    task wait_results(input int n);
        for (int i = 0; i < n; i++) begin
            for (int t = 0; t < 2000 && result_strobe !== 1'b1; t++) @(negedge sys_clk);
            check("strobe", result_strobe, 1);
            @(negedge sys_clk);
        end
    endtask

    // Main sequence
    initial begin
        do_reset(20);
        foreach (ptrs[i]) rd_chk(ptrs[i], rstv[i]);
        $display("test reset values done");
        foreach (dv[i]) begin
            wr_chk(`CDC_A_DAC_POS, {8'h00, dv[i]}, 1);
            wr_chk(`CDC_A_DAC_NEG, {8'h00, ~dv[i] & 8'hbf}, 1);
            @(negedge sys_clk);
            check("pos connect", pos_offset_dac_connect, dv[i][7]);
            check("pos code", pos_offset_dac_code, dv[i][5:0]);
            check("neg connect", neg_offset_dac_connect, !dv[i][7]);
            check("neg code", neg_offset_dac_code, 6'h3f ^ dv[i][5:0]);
            rd_chk(`CDC_A_DAC_POS, dv[i]);
        end
        $display("test offset dac done");
        wait_results(6);
        check("result unity", result_code, 24'h800000 + RAW);
        rd_chk(`CDC_A_RES_H, 8'h90);
        wr_chk(`CDC_A_CGAIN_H, 16'h4000, 2);
        wait_results(2);
        check("result half gain", result_code, 24'h800000 + (RAW >> 1));
        wr_chk(`CDC_A_VGAIN_H, 16'h5a3c, 2);
        rd_chk(`CDC_A_VGAIN_L, 8'h3c);
        rd_chk(`CDC_A_VGAIN_H, 8'h5a);
        wr_chk(`CDC_A_OFF_H, 16'h8123, 2);
        rd_chk(`CDC_A_OFF_H, 8'h81);
        rd_chk(`CDC_A_OFF_L, 8'h23);
        $display("test scaling done");
        do_reset(3);
        rd_chk(`CDC_A_OFF_H, 8'h80);
        rd_chk(`CDC_A_CGAIN_H, otp_cap_gain[15:8]);
        wait_results(6);
        check("result before cal", result_code, 24'h800000 + RAW);
        @(posedge sys_clk);
        cal_offset_start <= 1'b1;
        @(posedge sys_clk);
        cal_offset_start <= 1'b0;
        @(negedge sys_clk);
        check("cal busy", cal_busy, 1);
        for (int t = 0; t < 2000 && cal_busy !== 1'b0; t++) @(negedge sys_clk);
        check("cal done", cal_busy, 0);
        rd_chk(`CDC_A_OFF_H, 8'hc0);
        rd_chk(`CDC_A_OFF_L, 8'h00);
        wait_results(2);
        check("result after cal", result_code, `CDC_MID_CODE);
        $display("test calibration done");
        final_report;
    end

    // Watchdog: the sequence needs roughly 13000 cycles
    initial begin
        #600000;
        err_count++;
        final_report;
    end
endmodule
